// [rtl/i2c_slave_pkg.sv]
// shared constants and types for the i2c slave serial port
// assumes a single system clock domain; bus pins are sampled, never used as clocks
package i2c_slave_pkg;

   // ****************************************
   // mode field encodings
   // ****************************************
   localparam logic [3:0] MODE_SLAVE7       = 4'h6;
   localparam logic [3:0] MODE_SLAVE10      = 4'h7;
   localparam logic [3:0] MODE_MASTER_IDLE  = 4'hb;
   localparam logic [3:0] MODE_SLAVE7_SP    = 4'he;
   localparam logic [3:0] MODE_SLAVE10_SP   = 4'hf;

   // ****************************************
   // address and bit counting constants
   // ****************************************
   localparam logic [4:0] TEN_BIT_MARK      = 5'h1e;
   localparam logic [3:0] BITS_PER_BYTE     = 4'h8;
   localparam logic [3:0] ACK_PULSE         = 4'h9;
   localparam logic [7:0] OWN_ADDR_RESET    = 8'h00;
   localparam logic       PIN_LOW_LEVEL     = 1'b0;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic scl;
      logic sda;
   } bus_pins_t;

   // read-only status word, msb first
   typedef struct packed {
      logic data_not_addr;
      logic stop_seen;
      logic start_seen;
      logic read_not_write;
      logic update_due;
      logic buffer_full;
   } status_t;

   // gray coded along idle-shift-ack-tx-hold
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SHIFT = 3'b001,
      ST_ACK   = 3'b011,
      ST_TX    = 3'b010,
      ST_HOLD  = 3'b110
   } state_t;

endpackage

// [rtl/pin_sync.sv]
// two-flop synchronisers with edge detection for the bus pins
// assumes inputs are asynchronous to mclk_i
`timescale 1ns/1ns
module pin_sync
   import i2c_slave_pkg::*;
#(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   // raw pins
   input  wire logic [WIDTH-1:0] pin_i,
   // synchronised level and edges
   output logic      [WIDTH-1:0] level_o,
   output logic      [WIDTH-1:0] rise_o,
   output logic      [WIDTH-1:0] fall_o
);
   // ****************************************
   // per-pin chain
   // ****************************************
   if (WIDTH < 1) begin : g_bad
      $error("pin_sync needs at least one pin");
   end
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      logic meta;
      logic stable;
      logic prev;
      // bus idles high, so reset to one avoids a false stop edge
      always_ff @(posedge mclk_i or posedge rst_i) begin
         if (rst_i) begin
            meta   <= 1'b1;
            stable <= 1'b1;
            prev   <= 1'b1;
         end else begin
            meta   <= pin_i[i];
            stable <= meta;
            prev   <= stable;
         end
      end
      assign level_o[i] = stable;
      assign rise_o[i]  = stable & ~prev;
      assign fall_o[i]  = ~stable & prev;
   end
endmodule

// [rtl/addr_match.sv]
// own-address comparator for 7-bit, 10-bit header and 10-bit low byte
// purely combinational; caller decides when the result counts
`timescale 1ns/1ns
module addr_match
   import i2c_slave_pkg::*;
(
   // received byte and own address
   input  wire logic [7:0] shift_i,
   input  wire logic [7:0] own_i,
   // mode qualifiers
   input  wire logic       ten_bit_i,
   input  wire logic       expect_low_i,
   // results
   output logic            header_o,
   output logic            match_o
);
   // ****************************************
   // compare
   // ****************************************
   wire upper_eq = (shift_i[7:1] == own_i[7:1]);
   wire full_eq  = (shift_i == own_i);
   assign header_o = (shift_i[7:3] == TEN_BIT_MARK);
   // low byte compares all eight bits, r/w slot is an address bit there
   assign match_o  = expect_low_i ? full_eq : (upper_eq && (!ten_bit_i || header_o));
endmodule

// [rtl/i2c_slave_port.sv]
// slave-side i2c engine: address match, double-buffered receive, auto ack
// assumes software strobes are one-cycle pulses on mclk_i; pins are open drain
`timescale 1ns/1ns
// Overview of operation
// - port works only while enabled
// - mode field picks one of five modes
// - pins driven open drain when configured input
// - status word read only, reports bus state
// - full byte moves to buffer, flag set
// - byte while buffer unread sets overflow
// - matched bytes buffered and acked at once
// - full or overflow: no ack, buffer kept
// - buffer read clears full; overflow software-cleared
// - wait start, shift bits on scl rise
// - compare bits seven to one at eighth fall
// - match loads, sets full, acks, interrupts
// - five top bits mark ten-bit header
// - ten-bit address byte sets update, holds scl; code does neither for a low byte whose bit zero is one
// - read header sets only interrupt, full
// - write address clears direction, buffers address
// - interrupt per byte; software clears it
// - transmitter drives data pin when needed
// - no general call; start/stop interrupts given
// - master idle mode value recognised
// - start/stop bits cleared on reset, disable
module i2c_slave_port
   import i2c_slave_pkg::*;
(
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   // bus pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            scl_o,
   output logic            scl_oe_n_o,
   output logic            sda_o,
   output logic            sda_oe_n_o,
   // configuration
   input  wire logic       port_enable_bit_i,
   input  wire logic [3:0] mode_select_field_i,
   input  wire logic [1:0] pin_direction_bits_i,
   // software strobes
   input  wire logic       addr_wr_i,
   input  wire logic [7:0] addr_wdata_i,
   input  wire logic       buf_rd_i,
   input  wire logic       tx_wr_i,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       int_clear_i,
   input  wire logic       ovf_clear_i,
   // status
   output status_t         port_status_register_o,
   output logic            receive_overflow_flag_o,
   output logic            port_interrupt_flag_o,
   output logic [7:0]      transfer_buffer_o,
   output logic [7:0]      own_address_register_o
);
   // ****************************************
   // declarations
   // ****************************************
   bus_pins_t  pin_lvl;
   bus_pins_t  pin_rise;
   bus_pins_t  pin_fall;
   state_t     state;
   state_t     after_ack;
   logic [3:0] bit_cnt;
   logic [7:0] shift_register;
   logic [7:0] tx_shift;
   logic [7:0] transfer_buffer;
   logic [7:0] own_address_register;
   logic       buffer_full_flag;
   logic       receive_overflow_flag;
   logic       port_interrupt_flag;
   logic       address_update_due_flag;
   logic       start_seen;
   logic       stop_seen;
   logic       read_not_write;
   logic       data_not_addr;
   logic       addressed;
   logic       expect_low;
   logic       hi_ok;
   logic       tx_mode;
   logic       ack_drive;
   logic       hold_scl;
   logic       int_pend;
   logic       master_nack;
   logic       header;
   logic       addr_hit;
   logic       ten_bit;

   // ****************************************
   // pin synchronisers and comparator
   // ****************************************
   pin_sync #(.WIDTH(2)) u_sync (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .pin_i   ({scl_i, sda_i}),
      .level_o (pin_lvl),
      .rise_o  (pin_rise),
      .fall_o  (pin_fall)
   );

   addr_match u_match (
      .shift_i      (shift_register),
      .own_i        (own_address_register),
      .ten_bit_i    (ten_bit),
      .expect_low_i (expect_low),
      .header_o     (header),
      .match_o      (addr_hit)
   );

   // ****************************************
   // mode decode
   // ****************************************
   wire slave7     = (mode_select_field_i == MODE_SLAVE7) || (mode_select_field_i == MODE_SLAVE7_SP);
   assign ten_bit  = (mode_select_field_i == MODE_SLAVE10) || (mode_select_field_i == MODE_SLAVE10_SP);
   wire master_idl = (mode_select_field_i == MODE_MASTER_IDLE);
   wire sp_irq     = (mode_select_field_i == MODE_SLAVE7_SP) || (mode_select_field_i == MODE_SLAVE10_SP)
                     || master_idl;
   wire i2c_mode   = slave7 || ten_bit || master_idl;
   wire enabled    = port_enable_bit_i && i2c_mode;
   wire active     = port_enable_bit_i && (slave7 || ten_bit);
   wire pins_ok    = enabled && (&pin_direction_bits_i);

   // ****************************************
   // bus conditions and byte events
   // ****************************************
   wire start_det  = pin_lvl.scl && pin_fall.sda;
   wire stop_det   = pin_lvl.scl && pin_rise.sda;
   wire byte_done  = (state == ST_SHIFT) && pin_fall.scl && (bit_cnt == BITS_PER_BYTE);
   wire ack_fall   = (state == ST_ACK) && pin_fall.scl;
   wire tx_end     = (state == ST_TX) && pin_fall.scl && (bit_cnt == ACK_PULSE);
   wire rw_bit     = shift_register[0];
   wire addr_phase = !addressed;
   // a read header is only ours after a full ten-bit write address
   wire take_byte  = addressed || (addr_hit && (!ten_bit || expect_low || !rw_bit || hi_ok));
   wire ack_ok     = take_byte && !buffer_full_flag && !receive_overflow_flag;
   wire goes_tx    = ack_ok && addr_phase && rw_bit && !(ten_bit && expect_low);
   wire ua_byte    = take_byte && ten_bit && addr_phase && !rw_bit;
   wire ten_lo     = ten_bit && expect_low && addr_phase;
   wire ten_hw     = ten_bit && !expect_low && addr_phase && header && !rw_bit;
   wire load_buf   = byte_done && ack_ok;
   wire ovf_set    = byte_done && take_byte && !ack_ok;
   wire int_set    = (ack_fall && int_pend) || tx_end || (sp_irq && enabled && (start_det || stop_det));
   wire release_ok = tx_mode ? tx_wr_i : addr_wr_i;

   // ****************************************
   // next-state after the ack slot
   // ****************************************
   wire    addr_nack  = addr_phase && !ack_ok;
   state_t next_after;
   assign next_after = addr_nack ? ST_IDLE :
                       (goes_tx || (ua_byte && ack_ok)) ? ST_HOLD : ST_SHIFT;

   // ****************************************
   // pin drive, open drain only pulls low
   // ****************************************
   // bit zero stands until the eighth fall; letting go at the eighth rise would fake a stop
   wire tx_bit_low = (state == ST_TX) && (bit_cnt <= BITS_PER_BYTE) && !tx_shift[7];
   wire sda_drive  = pins_ok && (((state == ST_ACK) && ack_drive) || tx_bit_low);
   wire scl_drive  = pins_ok && hold_scl;
   assign sda_o      = PIN_LOW_LEVEL;
   assign scl_o      = PIN_LOW_LEVEL;
   assign sda_oe_n_o = ~sda_drive;
   assign scl_oe_n_o = ~scl_drive;

   // ****************************************
   // receive shifter and bit counter
   // ****************************************
   // samples sda on the synchronised scl rise; counter stops at eight, before the ack pulse
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_register <= 8'h00;
      end else if ((state == ST_SHIFT) && pin_rise.scl && (bit_cnt < BITS_PER_BYTE)) begin
         shift_register <= {shift_register[6:0], pin_lvl.sda};
      end
   end

   // ****************************************
   // main sequencer
   // ****************************************
   // start restarts the byte from any state; disable forces idle
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state      <= ST_IDLE;
         after_ack  <= ST_IDLE;
         bit_cnt    <= 4'h0;
         ack_drive  <= 1'b0;
         hold_scl   <= 1'b0;
         int_pend   <= 1'b0;
         addressed  <= 1'b0;
         expect_low <= 1'b0;
         hi_ok      <= 1'b0;
         tx_mode    <= 1'b0;
      end else if (!active) begin
         state      <= ST_IDLE;
         ack_drive  <= 1'b0;
         hold_scl   <= 1'b0;
         int_pend   <= 1'b0;
         addressed  <= 1'b0;
         expect_low <= 1'b0;
         hi_ok      <= 1'b0;
         tx_mode    <= 1'b0;
      end else if (start_det) begin
         state      <= ST_SHIFT;
         bit_cnt    <= 4'h0;
         ack_drive  <= 1'b0;
         hold_scl   <= 1'b0;
         addressed  <= 1'b0;
         expect_low <= 1'b0;
         tx_mode    <= 1'b0;
      end else if (stop_det) begin
         state      <= ST_IDLE;
         ack_drive  <= 1'b0;
         hold_scl   <= 1'b0;
         addressed  <= 1'b0;
         expect_low <= 1'b0;
         hi_ok      <= 1'b0;
         tx_mode    <= 1'b0;
      end else begin
         case (state)
            ST_SHIFT: begin
               if (pin_rise.scl && (bit_cnt < BITS_PER_BYTE)) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
               if (byte_done) begin
                  state     <= ST_ACK;
                  after_ack <= next_after;
                  ack_drive <= ack_ok;
                  int_pend  <= take_byte;
                  if (ten_hw && ack_ok) begin
                     expect_low <= 1'b1;
                  end
                  if (ten_lo) begin
                     expect_low <= 1'b0;
                     hi_ok      <= ack_ok;
                  end
                  if (addr_phase && ack_ok && !ten_hw) begin
                     addressed <= 1'b1;
                  end
                  if (goes_tx) begin
                     tx_mode <= 1'b1;
                  end
               end
            end
            ST_ACK: begin
               if (pin_fall.scl) begin
                  ack_drive <= 1'b0;
                  int_pend  <= 1'b0;
                  bit_cnt   <= 4'h0;
                  state     <= after_ack;
                  hold_scl  <= (after_ack == ST_HOLD);
               end
            end
            ST_HOLD: begin
               if (release_ok) begin
                  hold_scl <= 1'b0;
                  bit_cnt  <= 4'h0;
                  state    <= tx_mode ? ST_TX : ST_SHIFT;
               end
            end
            ST_TX: begin
               if (pin_rise.scl) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
               if (tx_end) begin
                  bit_cnt  <= 4'h0;
                  state    <= master_nack ? ST_IDLE : ST_HOLD;
                  hold_scl <= !master_nack;
                  tx_mode  <= !master_nack;
               end
            end
            default: begin
               bit_cnt <= 4'h0;
            end
         endcase
      end
   end

   // ****************************************
   // transmit shifter
   // ****************************************
   // loaded by the software write, shifted on each falling scl up to the eighth;
   // ones fill in so sda is free for the master's ack slot
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_shift <= 8'h00;
      end else if (tx_wr_i) begin
         tx_shift <= tx_data_i;
      end else if ((state == ST_TX) && pin_fall.scl && (bit_cnt <= BITS_PER_BYTE)) begin
         tx_shift <= {tx_shift[6:0], 1'b1};
      end
   end

   // master ack latched on the ninth rising scl
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         master_nack <= 1'b0;
      end else if ((state == ST_TX) && pin_rise.scl && (bit_cnt == BITS_PER_BYTE)) begin
         master_nack <= pin_lvl.sda;
      end
   end

   // ****************************************
   // buffer and own address
   // ****************************************
   // a received byte wins over a software transmit load in the same cycle
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         transfer_buffer <= 8'h00;
      end else if (load_buf) begin
         transfer_buffer <= shift_register;
      end else if (tx_wr_i) begin
         transfer_buffer <= tx_data_i;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         own_address_register <= OWN_ADDR_RESET;
      end else if (addr_wr_i) begin
         own_address_register <= addr_wdata_i;
      end
   end

   // ****************************************
   // sticky flags, set wins over clear
   // ****************************************
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         buffer_full_flag        <= 1'b0;
         receive_overflow_flag   <= 1'b0;
         port_interrupt_flag     <= 1'b0;
         address_update_due_flag <= 1'b0;
      end else begin
         buffer_full_flag        <= load_buf | (buffer_full_flag & ~buf_rd_i);
         receive_overflow_flag   <= ovf_set | (receive_overflow_flag & ~ovf_clear_i);
         port_interrupt_flag     <= int_set | (port_interrupt_flag & ~int_clear_i);
         address_update_due_flag <= (byte_done && ua_byte) | (address_update_due_flag & ~addr_wr_i);
      end
   end

   // ****************************************
   // status bits
   // ****************************************
   // start and stop each clear the other; both drop while disabled
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         start_seen     <= 1'b0;
         stop_seen      <= 1'b0;
         read_not_write <= 1'b0;
         data_not_addr  <= 1'b0;
      end else if (!enabled) begin
         start_seen     <= 1'b0;
         stop_seen      <= 1'b0;
         read_not_write <= 1'b0;
         data_not_addr  <= 1'b0;
      end else begin
         if (start_det) begin
            start_seen <= 1'b1;
            stop_seen  <= 1'b0;
         end else if (stop_det) begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b1;
         end
         if (byte_done && take_byte) begin
            data_not_addr <= addressed;
            if (addr_phase) begin
               read_not_write <= rw_bit && !(ten_bit && expect_low);
            end
         end
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign port_status_register_o = '{data_not_addr  : data_not_addr,
                                     stop_seen      : stop_seen,
                                     start_seen     : start_seen,
                                     read_not_write : read_not_write,
                                     update_due     : address_update_due_flag,
                                     buffer_full    : buffer_full_flag};
   assign receive_overflow_flag_o = receive_overflow_flag;
   assign port_interrupt_flag_o   = port_interrupt_flag;
   assign transfer_buffer_o       = transfer_buffer;
   assign own_address_register_o  = own_address_register;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   disabled_quiet_a:
      assert property (!port_enable_bit_i |-> sda_oe_n_o && scl_oe_n_o)
      else $error("pins driven while port disabled");
   overflow_set_a:
      assert property (byte_done && take_byte && buffer_full_flag |=> receive_overflow_flag)
      else $error("overflow not raised on full buffer");
   buffer_kept_a:
      assert property (byte_done && (buffer_full_flag || receive_overflow_flag) && !tx_wr_i
                       |=> $stable(transfer_buffer))
      else $error("buffer overwritten while full");
   ack_driven_a:
      assert property (byte_done && ack_ok && pins_ok && !start_det && !stop_det |=> !sda_oe_n_o)
      else $error("ack not driven on accepted byte");
   nack_release_a:
      assert property ((state == ST_ACK) && !ack_drive |-> sda_oe_n_o)
      else $error("sda pulled during withheld ack");
   ninth_irq_a:
      assert property (ack_fall && int_pend && active && !start_det && !stop_det |=> port_interrupt_flag)
      else $error("interrupt missing after ninth clock");
   read_clears_a:
      assert property (buf_rd_i && !load_buf |=> !buffer_full_flag)
      else $error("buffer read did not clear full flag");
   update_clear_a:
      assert property (addr_wr_i && !(byte_done && ua_byte) |=> !address_update_due_flag)
      else $error("address write did not clear update flag");
   disable_clear_a:
      assert property (!port_enable_bit_i |=> !start_seen && !stop_seen)
      else $error("start or stop kept while disabled");
endmodule

// [dv/i2c_master_model.sv]
// behavioural i2c bus master, 160 ns bit period
// assumes open-drain wires resolved by the bench with pull-ups
`timescale 1ns/1ns
module i2c_master_model (
   // alignment clock and resolved wires
   input  wire logic mclk_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   // pull-down requests, 1 = pull low
   output logic      scl_pull_o,
   output logic      sda_pull_o
);
   // *******************
   // bus phases
   // *******************
   initial begin
      scl_pull_o = 1'b0;
      sda_pull_o = 1'b0;
   end
   // waits out any stretch, so a held clock never gets cut short
   task automatic high(output logic smp);
      scl_pull_o = 1'b0;
      wait (scl_i);
      @(negedge mclk_i);
      #80 smp = sda_i;
      scl_pull_o = 1'b1;
      #40;
   endtask
   // also serves as repeated start
   task automatic start();
      sda_pull_o = 1'b0;
      #40 scl_pull_o = 1'b0;
      wait (scl_i);
      @(negedge mclk_i);
      #80 sda_pull_o = 1'b1;
      #80 scl_pull_o = 1'b1;
      #40;
   endtask
   task automatic stop();
      sda_pull_o = 1'b1;
      #40 scl_pull_o = 1'b0;
      wait (scl_i);
      @(negedge mclk_i);
      #80 sda_pull_o = 1'b0;
      #80;
   endtask
   // msb first; sda released in the ninth slot
   task automatic send(input logic [7:0] b, output logic ack, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sda_pull_o = !b[i];
         #40 high(rx[i]);
      end
      sda_pull_o = 1'b0;
      #40 high(ack);
      ack = !ack;
   endtask
endmodule

// [dv/tb.sv]
// self-checking bench for the i2c slave serial port
// assumes the master model and pull-ups on both wires
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
$display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
   import i2c_slave_pkg::*;
   logic       mclk_i, rst_i, en, ack, addr_wr, buf_rd, tx_wr, int_clr, ovf_clr;
   logic       scl_oe_n, sda_oe_n, scl_o, sda_o, scl_pull, sda_pull, ovf, irq;
   logic [3:0] mode;
   logic [1:0] dir;
   logic [7:0] wdata, txd, tbuf, own, rx;
   status_t    st;
   int         n_errors, total_checks;
   // wired-and with pull-ups
   wire logic  scl_w = !scl_pull && (scl_oe_n || scl_o);
   wire logic  sda_w = !sda_pull && (sda_oe_n || sda_o);
   i2c_slave_port i_i2c_slave_port (
      .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w),
      .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
      .port_enable_bit_i(en), .mode_select_field_i(mode), .pin_direction_bits_i(dir),
      .addr_wr_i(addr_wr), .addr_wdata_i(wdata), .buf_rd_i(buf_rd), .tx_wr_i(tx_wr),
      .tx_data_i(txd), .int_clear_i(int_clr), .ovf_clear_i(ovf_clr),
      .port_status_register_o(st), .receive_overflow_flag_o(ovf),
      .port_interrupt_flag_o(irq), .transfer_buffer_o(tbuf), .own_address_register_o(own));
   i2c_master_model i_i2c_master_model (
      .mclk_i(mclk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));
   // *******************
   // helpers and scenarios
   // *******************
   task automatic pulse(ref logic s);
      @(negedge mclk_i) s = 1'b1;
      @(negedge mclk_i) s = 1'b0;
   endtask
   task automatic set_own(input logic [7:0] v);
      wdata = v;
      pulse(addr_wr);
   endtask
   // flags land a few cycles after the ninth fall
   task automatic xfer(input logic [7:0] b);
      i_i2c_master_model.send(b, ack, rx);
      #100;
   endtask
   task automatic s_seven();
      set_own(8'ha0);
      i_i2c_master_model.start();
      xfer(8'ha0);
      `CHK("ack", 1'b1, ack)
      `CHK("buf", 8'ha0, tbuf)
      `CHK("status", 6'h09, st)
      `CHK("irq", 1'b1, irq)
      pulse(buf_rd);
      pulse(int_clr);
      `CHK("bf", 1'b0, st.buffer_full)
      xfer(8'h3c);
      `CHK("data", 8'h3c, tbuf)
      `CHK("status", 6'h29, st)
      pulse(int_clr);
      xfer(8'h55);
      `CHK("nack", 1'b0, ack)
      `CHK("kept", 8'h3c, tbuf)
      `CHK("ovf", 1'b1, ovf)
      `CHK("irq", 1'b1, irq)
      pulse(ovf_clr);
      pulse(buf_rd);
      pulse(int_clr);
      `CHK("ovf", 1'b0, ovf)
      i_i2c_master_model.stop();
      #100;
      `CHK("stop", 1'b1, st.stop_seen)
   endtask
   task automatic s_refuse();
      i_i2c_master_model.start();
      xfer(8'h42);
      `CHK("miss", 2'b00, {ack, irq})
      i_i2c_master_model.stop();
      en = 1'b0;
      #100;
      `CHK("s p", 2'b00, {st.stop_seen, st.start_seen})
      i_i2c_master_model.start();
      xfer(8'ha0);
      `CHK("off", 1'b0, ack)
      i_i2c_master_model.stop();
      en = 1'b1;
      // one pin left as output: the port must not drive at all
      dir = 2'b01;
      i_i2c_master_model.start();
      xfer(8'ha0);
      `CHK("dir", 1'b0, ack)
      i_i2c_master_model.stop();
      pulse(buf_rd);
      pulse(int_clr);
      dir = 2'b11;
   endtask
   task automatic s_ten();
      mode = MODE_SLAVE10;
      set_own(8'hf2);
      i_i2c_master_model.start();
      xfer(8'hf2);
      `CHK("hdr", 1'b1, ack)
      `CHK("held", 2'b10, {st.update_due, scl_oe_n})
      set_own(8'h34);
      `CHK("free", 2'b01, {st.update_due, scl_oe_n})
      pulse(buf_rd);
      pulse(int_clr);
      xfer(8'h34);
      `CHK("low", 3'b111, {ack, st.update_due, irq})
      set_own(8'hf2);
      pulse(buf_rd);
      pulse(int_clr);
      xfer(8'h99);
      `CHK("data", 8'h99, tbuf)
      pulse(buf_rd);
      i_i2c_master_model.start();
      xfer(8'hf3);
      `CHK("rd", 4'b1011, {ack, st.update_due, st.read_not_write, st.buffer_full})
      txd = 8'h5a;
      pulse(tx_wr);
      xfer(8'hff);
      `CHK("tx", 8'h5a, rx)
      i_i2c_master_model.stop();
   endtask
   // start interrupt only where the mode asks for it
   task automatic s_modes();
      logic [3:0] m [3] = '{MODE_SLAVE7, MODE_SLAVE7_SP, MODE_MASTER_IDLE};
      for (int k = 0; k < 3; k++) begin
         mode = m[k];
         pulse(int_clr);
         i_i2c_master_model.start();
         #100;
         `CHK("start irq", k > 0, irq)
         i_i2c_master_model.stop();
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // about 140 bit times of traffic; far beyond that is a hang
   initial begin
      #300000;
      n_errors++;
      wrap_up();
   end
   initial begin
      {rst_i, en, addr_wr, buf_rd, tx_wr, int_clr, ovf_clr} = 7'h60;
      mode = MODE_SLAVE7;
      dir = 2'b11;
      {wdata, txd} = '0;
      repeat (5) @(negedge mclk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge mclk_i);
      `CHK("own", OWN_ADDR_RESET, own)
      s_seven();
      s_refuse();
      s_ten();
      s_modes();
      wrap_up();
   end
endmodule
